// ==== two_wire_eeprom.sv ====
`timescale 1ns/1ps
// What this block does
// - Data line changes only while clock low, except start and stop.
// - Sample incoming bits on clock rise, shift outgoing bits on clock fall.
// - Data falling while clock high is a start; device detects it.
// - Data rising while clock high is a stop; reads then return to standby.
// - Stop after a write runs a timed programming cycle ignoring the pins.
// - Programming cycle lasts at most 10 ms, or 15 ms at low supply.
// - Words are eight bits, MSB first; receiver pulls low on ninth clock.
// - Writes acknowledge every byte; reads acknowledge only the address word.
// - After a read byte release; low ack sends next, high ack idles.
// - Address word: type code, three select bits, then direction bit.
// - Mismatch means no acknowledge and standby; match acknowledges and proceeds.
// - Select straps read low when unconnected (no pull-down here, pins sampled as driven); eight devices may share.
// - Write-protect high blocks all writes; reads always work.
// - Byte write: address word, two address bytes, data, each acknowledged.
// - Array holds 4096 or 8192 bytes, using 12 or 13 address bits.
// - Up to 32 data bytes per page; only five low bits increment.
// - Past page end the offset wraps, overwriting buffered data.
// - Write address word during programming gets no acknowledge, afterwards acknowledged.
// - Counter holds last address plus one; current read returns that byte.
// - Read of last location wraps to zero; write wraps within page.
// - Random read: dummy write of address, new start, read word.
// - Sequential read advances on each low ack, wrapping whole array.
module two_wire_eeprom #(
	parameter int memBytes = eeprom_pkg::MEM_BYTES_SMALL,
	parameter int progCycles = eeprom_pkg::PROG_CYCLES,
	parameter logic [3:0] typeCode = eeprom_pkg::TYPE_CODE_DEFAULT
) (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic sclPin, // Serial clock pin
	input wire logic sdaIn, // Data line level
	output logic sdaOut, // Data line drive value
	output logic sdaOe, // Pulls data line low when high
	input wire logic selectStrapBit0, // Select strap bit 0
	input wire logic selectStrapBit1, // Select strap bit 1
	input wire logic selectStrapBit2, // Select strap bit 2
	input wire logic writeProtect, // Write-protect pin
	output logic progBusy // Programming cycle running
);
	localparam int AW = $clog2(memBytes);

	if ((memBytes != eeprom_pkg::MEM_BYTES_SMALL && memBytes != eeprom_pkg::MEM_BYTES_LARGE)
		|| progCycles < 40) begin : gBadParam
		$error("two_wire_eeprom: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and line events
	eeprom_pkg::pins_t meta_q;
	eeprom_pkg::pins_t sync_q;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	// Two flops before any use
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= eeprom_pkg::PINS_IDLE;
			sync_q <= eeprom_pkg::PINS_IDLE;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			meta_q <= '{scl: sclPin, sda: sdaIn, wp: writeProtect,
				strap: {selectStrapBit2, selectStrapBit1, selectStrapBit0}};
			sync_q <= meta_q;
			sclPrev_q <= sync_q.scl;
			sdaPrev_q <= sync_q.sda;
		end
	end

	// Edge and condition decode
	assign sclRise = sync_q.scl && !sclPrev_q;
	assign sclFall = !sync_q.scl && sclPrev_q;
	assign startSeen = sync_q.scl && sclPrev_q && sdaPrev_q && !sync_q.sda;
	assign stopSeen = sync_q.scl && sclPrev_q && !sdaPrev_q && sync_q.sda;

	////////////////////////////////////////////////////////////////////////////////
	// Protocol state
	eeprom_pkg::state_t state_q;
	logic [3:0] bitCnt_q;
	logic [1:0] byteIdx_q;
	logic [7:0] shift_q;
	logic readMode_q;
	logic sdaLow_q;
	logic wrote_q;
	logic [7:0] addrHi_q;
	logic [AW-1:0] addrCnt_q;
	logic [31:0] mask_q;
	logic [31:0] timer_q;
	logic [5:0] copyIdx_q;
	logic copyValid_q;
	logic [4:0] copyAddr_q;
	logic [7:0] arrayRd;
	logic [7:0] pageRd;
	logic byteDone;
	logic devMatch;
	logic byteAck;
	logic loadByte;
	logic dataByte;
	logic progDone;
	logic pushValid;
	logic pushReady;
	logic popValid;
	logic popReady;
	eeprom_pkg::pageWord_t pushWord;
	eeprom_pkg::pageWord_t popWord;

	function automatic logic addrMatch(input logic [7:0] word, input logic [2:0] strap,
		input logic [3:0] code);
		return word[7:4] == code && word[3:1] == strap;
	endfunction

	// Word events
	assign byteDone = state_q == eeprom_pkg::ST_RECV && sclFall && bitCnt_q == eeprom_pkg::BIT_LAST;
	assign devMatch = addrMatch(shift_q, sync_q.strap, typeCode);
	assign dataByte = byteDone && byteIdx_q == eeprom_pkg::IDX_DATA;
	assign byteAck = (byteIdx_q == eeprom_pkg::IDX_DEV) ? devMatch
		: (!dataByte || pushReady || sync_q.wp);
	assign loadByte = sclFall && ((state_q == eeprom_pkg::ST_ACK && readMode_q)
		|| (state_q == eeprom_pkg::ST_MACK && bitCnt_q == eeprom_pkg::BIT_LAST));
	assign progDone = timer_q >= 32'(progCycles - 1) && copyIdx_q == eeprom_pkg::COPY_LAST;

	// Main sequencer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= eeprom_pkg::ST_IDLE;
			bitCnt_q <= 4'h0;
			byteIdx_q <= eeprom_pkg::IDX_DEV;
			shift_q <= 8'h00;
			readMode_q <= 1'b0;
			sdaLow_q <= 1'b0;
		end else if (state_q == eeprom_pkg::ST_PROG) begin
			sdaLow_q <= 1'b0;
			if (progDone) begin
				state_q <= eeprom_pkg::ST_IDLE;
			end
		end else if (startSeen) begin
			state_q <= eeprom_pkg::ST_RECV;
			bitCnt_q <= 4'h0;
			byteIdx_q <= eeprom_pkg::IDX_DEV;
			sdaLow_q <= 1'b0;
		end else if (stopSeen) begin
			state_q <= (wrote_q && !sync_q.wp) ? eeprom_pkg::ST_PROG : eeprom_pkg::ST_IDLE;
			sdaLow_q <= 1'b0;
		end else begin
			case (state_q)
				eeprom_pkg::ST_RECV: begin
					if (sclRise && bitCnt_q != eeprom_pkg::BIT_LAST) begin
						shift_q <= {shift_q[6:0], sync_q.sda};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (byteDone) begin
						if (byteIdx_q == eeprom_pkg::IDX_DEV) begin
							readMode_q <= shift_q[0];
						end
						if (byteAck) begin
							state_q <= eeprom_pkg::ST_ACK;
							sdaLow_q <= 1'b1;
						end else begin
							state_q <= eeprom_pkg::ST_IDLE;
						end
					end
				end
				eeprom_pkg::ST_ACK: begin
					if (loadByte) begin
						state_q <= eeprom_pkg::ST_SEND;
						shift_q <= arrayRd;
						bitCnt_q <= 4'h0;
						sdaLow_q <= !arrayRd[7];
					end else if (sclFall) begin
						state_q <= eeprom_pkg::ST_RECV;
						bitCnt_q <= 4'h0;
						sdaLow_q <= 1'b0;
						if (byteIdx_q != eeprom_pkg::IDX_DATA) begin
							byteIdx_q <= byteIdx_q + 2'h1;
						end
					end
				end
				eeprom_pkg::ST_SEND: begin
					if (sclFall) begin
						if (bitCnt_q == eeprom_pkg::BIT_SENT) begin
							state_q <= eeprom_pkg::ST_MACK;
							bitCnt_q <= 4'h0;
							sdaLow_q <= 1'b0;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sdaLow_q <= !shift_q[6];
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
				end
				eeprom_pkg::ST_MACK: begin
					if (loadByte) begin
						state_q <= eeprom_pkg::ST_SEND;
						shift_q <= arrayRd;
						bitCnt_q <= 4'h0;
						sdaLow_q <= !arrayRd[7];
					end else if (sclRise) begin
						if (sync_q.sda) begin
							state_q <= eeprom_pkg::ST_IDLE;
						end else begin
							bitCnt_q <= eeprom_pkg::BIT_LAST;
						end
					end
				end
				default: begin
					sdaLow_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address counter
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addrHi_q <= 8'h00;
			addrCnt_q <= '0;
		end else if (loadByte) begin
			addrCnt_q <= addrCnt_q + AW'(1);
		end else if (byteDone && byteAck) begin
			if (byteIdx_q == eeprom_pkg::IDX_HI) begin
				addrHi_q <= shift_q;
			end else if (byteIdx_q == eeprom_pkg::IDX_LO) begin
				addrCnt_q <= AW'({addrHi_q, shift_q});
			end else if (byteIdx_q == eeprom_pkg::IDX_DATA) begin
				addrCnt_q[4:0] <= addrCnt_q[4:0] + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Page gathering through the two-entry buffer
	assign pushValid = dataByte && !sync_q.wp;
	assign pushWord = '{offset: addrCnt_q[4:0], data: shift_q};
	assign popReady = state_q != eeprom_pkg::ST_PROG;

	pair_buffer #(
		.WIDTH($bits(eeprom_pkg::pageWord_t))
	) uBuffer (
		.clk(mclk),
		.rst(sys_rst),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData(pushWord),
		.outValid(popValid),
		.outReady(popReady),
		.outData(popWord)
	);

	// Written-flag; a pushed byte wins over the clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wrote_q <= 1'b0;
		end else if (pushValid && pushReady) begin
			wrote_q <= 1'b1;
		end else if ((byteDone && byteIdx_q == eeprom_pkg::IDX_DEV) || progDone) begin
			wrote_q <= 1'b0;
		end
	end

	// Page slot occupancy; set wins over clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mask_q <= 32'h0000_0000;
		end else begin
			mask_q <= ((byteDone && byteIdx_q == eeprom_pkg::IDX_DEV) || progDone) ? 32'h0000_0000 : mask_q;
			if (popValid && popReady) begin
				mask_q[popWord.offset] <= 1'b1;
			end
		end
	end

	eeprom_mem #(
		.DEPTH(eeprom_pkg::PAGE_BYTES),
		.WIDTH(eeprom_pkg::BYTE_BITS)
	) uPage (
		.clk(mclk),
		.wrEn(popValid && popReady),
		.wrAddr(popWord.offset),
		.wrData(popWord.data),
		.rdAddr(copyIdx_q[4:0]),
		.rdData(pageRd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Programming cycle: page copy and timer
	always_ff @(posedge mclk) begin
		if (sys_rst || state_q != eeprom_pkg::ST_PROG) begin
			timer_q <= 32'h0000_0000;
			copyIdx_q <= 6'h00;
			copyValid_q <= 1'b0;
			copyAddr_q <= 5'h00;
		end else begin
			timer_q <= timer_q + 32'h0000_0001;
			copyValid_q <= copyIdx_q != eeprom_pkg::COPY_LAST && mask_q[copyIdx_q[4:0]];
			copyAddr_q <= copyIdx_q[4:0];
			if (copyIdx_q != eeprom_pkg::COPY_LAST) begin
				copyIdx_q <= copyIdx_q + 6'h01;
			end
		end
	end

	eeprom_mem #(
		.DEPTH(memBytes),
		.WIDTH(eeprom_pkg::BYTE_BITS)
	) uArray (
		.clk(mclk),
		.wrEn(copyValid_q),
		.wrAddr({addrCnt_q[AW-1:eeprom_pkg::PAGE_BITS], copyAddr_q}),
		.wrData(pageRd),
		.rdAddr(addrCnt_q),
		.rdData(arrayRd)
	);

	// Open-drain data drive and status
	assign sdaOut = 1'b0;
	assign sdaOe = sdaLow_q;
	assign progBusy = state_q == eeprom_pkg::ST_PROG;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence sDevWord;
		byteDone && byteIdx_q == eeprom_pkg::IDX_DEV;
	endsequence
	sequence sReadNack;
		state_q == eeprom_pkg::ST_MACK && sclRise && sync_q.sda;
	endsequence
	AST_DRIVE_ON_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(sdaOe) && !$past(stopSeen) && !$past(startSeen) |-> !sync_q.scl)
		else $error("data line drive changed while clock high");
	AST_ACK_MATCH: assert property (@(posedge mclk) disable iff (sys_rst)
		sDevWord and devMatch |=> sdaOe && state_q == eeprom_pkg::ST_ACK)
		else $error("matching address word not acknowledged");
	AST_NO_ACK_MISMATCH: assert property (@(posedge mclk) disable iff (sys_rst)
		sDevWord and !devMatch |=> !sdaOe && state_q == eeprom_pkg::ST_IDLE)
		else $error("mismatching address word acknowledged");
	AST_START: assert property (@(posedge mclk) disable iff (sys_rst)
		startSeen && state_q != eeprom_pkg::ST_PROG |=> state_q == eeprom_pkg::ST_RECV
		&& bitCnt_q == 4'h0)
		else $error("start not taken");
	AST_READ_STOP: assert property (@(posedge mclk) disable iff (sys_rst)
		sReadNack ##[1:40] stopSeen |=> state_q == eeprom_pkg::ST_IDLE && !sdaOe)
		else $error("no standby after read ends");
	AST_PROG_ENTRY: assert property (@(posedge mclk) disable iff (sys_rst)
		stopSeen && wrote_q && !sync_q.wp && state_q != eeprom_pkg::ST_PROG
		|=> progBusy ##1 progBusy)
		else $error("programming cycle not started");
	AST_PROG_SILENT: assert property (@(posedge mclk) disable iff (sys_rst)
		progBusy |-> !sdaOe)
		else $error("device drove line while programming");
	AST_WP_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
		sync_q.wp && !progBusy && (dataByte || stopSeen) |-> !pushValid ##1 !progBusy && !wrote_q)
		else $error("protected write reached page buffer");
	AST_PAGE_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
		dataByte && byteAck |=> addrCnt_q[AW-1:5] == $past(addrCnt_q[AW-1:5])
		&& addrCnt_q[4:0] == $past(addrCnt_q[4:0]) + 5'h01)
		else $error("page address did not wrap in page");
	AST_READ_ADVANCE: assert property (@(posedge mclk) disable iff (sys_rst)
		loadByte |=> addrCnt_q == $past(addrCnt_q) + AW'(1) && state_q == eeprom_pkg::ST_SEND)
		else $error("read did not advance address");
endmodule // two_wire_eeprom

// ==== eeprom_pkg.sv ====
package eeprom_pkg;
	// Clock and programming time
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_MS = 10; // programming_cycle_time, upper supply range
	localparam int PROG_TIME_LOW_MS = 15; // programming_cycle_time, lowest supply range
	localparam int PROG_CYCLES = PROG_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int PROG_CYCLES_LOW = PROG_TIME_LOW_MS * 1_000_000 / CLK_PERIOD_NS;

	// Array and page geometry
	localparam int MEM_BYTES_SMALL = 4096;
	localparam int MEM_BYTES_LARGE = 8192;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_BITS = 5;
	localparam int BYTE_BITS = 8;

	// Word framing
	localparam logic [3:0] BIT_LAST = 4'h8; // eight bits taken, ninth clock next
	localparam logic [3:0] BIT_SENT = 4'h7;
	localparam logic [1:0] IDX_DEV = 2'h0;
	localparam logic [1:0] IDX_HI = 2'h1;
	localparam logic [1:0] IDX_LO = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;
	localparam logic [5:0] COPY_LAST = 6'h20;
	localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h6; // Arbitrary value

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_ACK = 6'h04,
		ST_SEND = 6'h08,
		ST_MACK = 6'h10,
		ST_PROG = 6'h20
	} state_t;

	typedef struct packed {
		logic [4:0] offset;
		logic [7:0] data;
	} pageWord_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] strap;
	} pins_t;

	localparam pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
endpackage

// ==== eeprom_mem.sv ====
`timescale 1ns/1ps
module eeprom_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8
) (
	input wire logic clk, // System clock
	input wire logic wrEn, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wrAddr, // Write address
	input wire logic [WIDTH-1:0] wrData, // Write data
	input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read address
	output logic [WIDTH-1:0] rdData // Registered read data
);
	if (DEPTH < 2 || WIDTH < 1) begin : gBadSize
		$error("eeprom_mem: bad size");
	end

	logic [WIDTH-1:0] cells [DEPTH];

	// Write port
	always_ff @(posedge clk) begin
		if (wrEn) begin
			cells[wrAddr] <= wrData;
		end
	end

	// Registered read port
	always_ff @(posedge clk) begin
		rdData <= cells[rdAddr];
	end
endmodule // eeprom_mem

// ==== pair_buffer.sv ====
`timescale 1ns/1ps
module pair_buffer #(
	parameter int WIDTH = 13
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic inValid, // Word offered
	output logic inReady, // Room for a word
	input wire logic [WIDTH-1:0] inData, // Offered word
	output logic outValid, // Word held
	input wire logic outReady, // Drain takes word
	output logic [WIDTH-1:0] outData // Oldest word
);
	if (WIDTH < 1) begin : gBadWidth
		$error("pair_buffer: bad width");
	end

	logic [WIDTH-1:0] slot_q [2];
	logic [1:0] count_q;
	logic head_q;
	logic tail_q;
	logic push;
	logic pop;

	// Handshake terms
	assign inReady = count_q != 2'h2;
	assign outValid = count_q != 2'h0;
	assign outData = slot_q[head_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			slot_q[tail_q] <= inData;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= 2'h0;
			head_q <= 1'b0;
			tail_q <= 1'b0;
		end else begin
			if (push) begin
				tail_q <= ~tail_q;
			end
			if (pop) begin
				head_q <= ~head_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // pair_buffer

// ==== host_model.sv ====
`timescale 1ns/1ps
////////////////////////////////
// Two-wire bus controller model
module host_model (
	input wire logic mclk, // System clock
	input wire logic sdaLine, // Resolved data line
	output logic sclPin, // Serial clock drive
	output logic hostLow, // Host pulls data low
	output logic resStrobe, // Byte result ready
	output logic [8:0] resWord // Eight bits seen and ninth bit
);
	// Idle bus: clock high, line released to the pull-up
	initial begin
		sclPin = 1'b1;
		hostLow = 1'b0;
		resStrobe = 1'b0;
		resWord = 9'h000;
	end
	////////////////////////////////
	// Whole clock cycles, stepping on the falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Data falls with clock high; also serves as repeated start
	task automatic start();
		hostLow = 1'b0;
		tick(4);
		sclPin = 1'b1;
		tick(8);
		hostLow = 1'b1;
		tick(8);
		sclPin = 1'b0;
		tick(4);
	endtask
	// Data rises with clock high; clock then stands high
	task automatic stop();
		hostLow = 1'b1;
		tick(4);
		sclPin = 1'b1;
		tick(8);
		hostLow = 1'b0;
		tick(8);
	endtask
	// Eight bits MSB first plus ninth bit; line read late in high phase
	task automatic xfer(input logic [7:0] tx, input logic ackIn);
		logic [8:0] word;
		logic [8:0] seen;
		word = {tx, ackIn};
		for (int i = 8; i >= 0; i--) begin
			hostLow = ~word[i];
			tick(4);
			sclPin = 1'b1;
			tick(7);
			seen[i] = sdaLine;
			tick(1);
			sclPin = 1'b0;
			tick(4);
		end
		resWord = seen;
		resStrobe = 1'b1;
		tick(1);
		resStrobe = 1'b0;
	endtask
endmodule // host_model

// ==== test_two_wire_eeprom.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
////////////////////////////////
// Bench for the two-wire memory target
module test_two_wire_eeprom;
	localparam int PROG = 200; // Shortened programming time
	localparam logic [3:0] TC = 4'h9; // Arbitrary type code
	logic mclk = 1'b0;
	logic sysRst = 1'b1;
	logic writeProtect = 1'b0;
	logic [2:0] strap = 3'h0;
	logic sclPin, hostLow, resStrobe, sdaOut, sdaOe, progBusy;
	logic [8:0] resWord;
	logic [8:0] expWord;
	wire sdaLine;
	logic [7:0] memRef [0:4095];
	logic [8:0] expQ [$];
	int n_fail = 0;
	int samples_checked = 0;
	int busyRun = 0;
	integer seed = 32'h28a4;

	// Clock and open-drain wire with pull-up
	always #5 mclk = ~mclk;
	assign sdaLine = ~((sdaOe & ~sdaOut) | hostLow);

	two_wire_eeprom #(.progCycles(PROG), .typeCode(TC)) two_wire_eeprom_i (
		.mclk(mclk), .sys_rst(sysRst), .sclPin(sclPin), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .selectStrapBit0(strap[0]),
		.selectStrapBit1(strap[1]), .selectStrapBit2(strap[2]),
		.writeProtect(writeProtect), .progBusy(progBusy));
	host_model host_model_i (.mclk(mclk), .sdaLine(sdaLine), .sclPin(sclPin),
		.hostLow(hostLow), .resStrobe(resStrobe), .resWord(resWord));

	////////////////////////////////
	// Verdict and end of run
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Oldest note against each byte result; length of each busy period
	always @(posedge mclk) begin
		if (resStrobe === 1'b1) begin
			expWord = (expQ.size() > 0) ? expQ.pop_front() : 9'h000;
			`CHK("byte and ninth bit", expWord, resWord)
		end
		if (progBusy === 1'b1) begin
			busyRun++;
		end else if (busyRun != 0) begin
			`CHK("busy cycles", PROG, busyRun)
			busyRun = 0;
		end
	end

	////////////////////////////////
	// Byte sent by host; ninth bit expected from the device
	task automatic wb(input logic [7:0] d, input logic ack);
		expQ.push_back({d, ack});
		host_model_i.xfer(d, 1'b1);
	endtask
	// Byte read from the device; host answers with last
	task automatic rb(input logic [11:0] a, input logic last);
		expQ.push_back({memRef[a], last});
		host_model_i.xfer(8'hFF, last);
	endtask
	// Bounded wait for the busy level
	task automatic waitBusy(input logic lvl);
		int i;
		for (i = 0; i < 400 && progBusy !== lvl; i++) @(negedge mclk);
		if (i == 400) begin
			n_fail++;
			$display("ERROR progBusy expected %h seen %h", lvl, progBusy);
			test_done();
		end
	endtask
	// Dummy write sets the counter, then n bytes are read
	task automatic rdAt(input logic [11:0] a, input int n);
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b0);
		wb({4'h0, a[11:8]}, 1'b0);
		wb(a[7:0], 1'b0);
		host_model_i.start();
		wb({TC, strap, 1'b1}, 1'b0);
		for (int k = 0; k < n; k++) rb(a + 12'(k), k == n - 1);
		host_model_i.stop();
	endtask

	////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d;
		strap = 3'($random(seed));
		repeat (8) @(negedge mclk);
		sysRst = 1'b0;
		repeat (4) @(negedge mclk);
		// Page write from the last offset with upper bits set
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b0);
		wb(8'hF0, 1'b0);
		wb(8'h1F, 1'b0);
		for (int k = 0; k < 3; k++) begin
			d = 8'($random(seed));
			memRef[12'(5'(31 + k))] = d;
			wb(d, 1'b0);
		end
		host_model_i.stop();
		waitBusy(1'b1);
		// Polling: refused while busy, taken afterwards
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b1);
		host_model_i.stop();
		waitBusy(1'b0);
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b0);
		host_model_i.stop();
		// Byte write to the last location
		d = 8'($random(seed));
		memRef[12'hFFF] = d;
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b0);
		wb(8'hFF, 1'b0);
		wb(8'hFF, 1'b0);
		wb(d, 1'b0);
		host_model_i.stop();
		waitBusy(1'b1);
		waitBusy(1'b0);
		// Read across the array end, then from the counter
		rdAt(12'hFFF, 2);
		host_model_i.start();
		wb({TC, strap, 1'b1}, 1'b0);
		rb(12'h001, 1'b1);
		host_model_i.stop();
		// Protected write is acknowledged but changes nothing
		writeProtect = 1'b1;
		host_model_i.start();
		wb({TC, strap, 1'b0}, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'h00, 1'b0);
		wb(~memRef[0], 1'b0);
		host_model_i.stop();
		repeat (20) @(negedge mclk);
		`CHK("progBusy", 1'b0, progBusy)
		rdAt(12'h000, 2);
		writeProtect = 1'b0;
		// Foreign strap and foreign type code stay silent
		host_model_i.start();
		wb({TC, ~strap, 1'b0}, 1'b1);
		host_model_i.stop();
		host_model_i.start();
		wb({~TC, strap, 1'b1}, 1'b1);
		host_model_i.stop();
		repeat (20) @(negedge mclk);
		test_done();
	end
endmodule // test_two_wire_eeprom
